//--- shared/crcg_pkg.sv
// constants shared by the programmable crc generator files
package crcg_pkg;

   // bus geometry
   localparam int ADDR_W = 5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // register byte offsets
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_POLY = 5'h04;
   localparam logic [4:0] OFS_WDAT = 5'h08;
   localparam logic [4:0] OFS_RESULT = 5'h0C;

   // crc_control field positions
   localparam int CTRL_POLY_LENGTH_FIELD_LSB = 0;
   localparam int CTRL_GO_BIT = 4;
   localparam int CTRL_EMPTY_BIT = 6;
   localparam int CTRL_FULL_BIT = 7;
   localparam int CTRL_COUNT_LSB = 8;
   localparam int CTRL_IDLE_BIT = 13;

   // crc_polynomial_terms field
   localparam int POLY_LSB = 1;

   // reset values
   localparam logic [15:0] RST_POLY = 16'h0000;
   localparam logic [3:0] RST_POLY_LENGTH_FIELD = 4'h0;
   localparam logic [15:0] RST_CRC = 16'h0000;

   // fifo geometry
   localparam int WORD_W = 16;
   localparam int FIFO_AW = 4;
   localparam int FIFO_WORDS = 16;
   localparam logic [3:0] POLY_LENGTH_FIELD_SHORT_MAX = 4'h7;
   localparam logic [4:0] DEPTH_LONG = 5'h08;
   localparam logic [4:0] DEPTH_SHORT = 5'h10;
   localparam logic [3:0] PTR_MASK_LONG = 4'h7;
   localparam logic [3:0] PTR_MASK_SHORT = 4'hF;

   // shift engine
   localparam logic [4:0] BITS_PER_CLK = 5'h02;

endpackage

//--- rtl/crcg_fifo_mem.sv
// word store of the crc input fifo, registered read port
`timescale 1ns/100ps
module crcg_fifo_mem
   import crcg_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wr_en,
   input wire logic [FIFO_AW-1:0] wr_addr,
   input wire logic [WORD_W-1:0] wr_data,
   input wire logic [FIFO_AW-1:0] rd_addr,
   output logic [WORD_W-1:0] rd_data
);

   typedef struct packed {
      logic [FIFO_WORDS-1:0][WORD_W-1:0] mem;
      logic [WORD_W-1:0] rdata;
   } crcg_mem_state_t;

   crcg_mem_state_t s;
   crcg_mem_state_t next_s;

   always_comb begin
      next_s = s;
      // read sees the old word on a same-address write
      next_s.rdata = s.mem[rd_addr];
      if (wr_en) begin
         next_s.mem[wr_addr] = wr_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rd_data = s.rdata;

endmodule

//--- rtl/crcg_top.sv
// programmable crc generator with input fifo and axi4-lite registers
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// Function
// R01 - software picks polynomial terms and length
// R02 - x^0 always used, top term implied
// R03 - software writes one to go bit
// R04 - fifo depth 8 if length>7, else 16
// R05 - word width length+1, excess bits ignored
// R06 - count increments when word msb written
// R07 - go and count>0 pops word, decrements count
// R08 - last bit done (length+1)/2 clocks later
// R09 - full flag at depth, empty at zero
// R10 - write when full wraps count, no event
// R11 - event when count falls one to zero
// R12 - software waits empty before reading result
// R13 - software waits a cycle before count read
// R14 - software primes fifo, polls count
// R15 - software drains fifo with go bit
// R16 - sleep freezes state, resumes after
// R17 - idle stop bit selects idle freeze
// R18 - control low byte: full, empty, go, length
// R19 - go bit starts and stops shifter
// R20 - two bits per clock msb first lfsr
module crcg_top
   import crcg_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_mode,
   input wire logic idle_mode,
   output logic crc_event
);

   typedef struct packed {
      logic aw_got;
      logic [2:0] aw_idx;
      logic w_got;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [15:0] rdata;
      logic [1:0] rresp;
      logic idle_stop;
      logic shifter_go;
      logic [3:0] poly_length_field;
      logic [15:1] poly_terms;
      logic [4:0] valid_word_count;
      logic [3:0] wr_ptr;
      logic [3:0] rd_ptr;
      logic [7:0] stage_lo;
      logic load_pend;
      logic [15:0] shreg;
      logic [4:0] bits_left;
      logic [15:0] crc;
      logic event_q;
   } crcg_state_t;

   crcg_state_t s;
   crcg_state_t next_s;

   logic fifo_we;
   logic [FIFO_AW-1:0] fifo_waddr;
   logic [WORD_W-1:0] fifo_wdata;
   logic [WORD_W-1:0] fifo_rdata;

   ////////////////////////////////////////////////////////////////////////
   // one lfsr step; top term is the bit shifted out of the width
   function automatic logic [15:0] crcg_step(
      input logic [15:0] c,
      input logic b,
      input logic [3:0] pl,
      input logic [15:0] taps,
      input logic [15:0] m
   );
      logic fb;
      fb = c[pl] ^ b;
      crcg_step = ((c << 1) & m) ^ (fb ? (taps & m) : 16'h0000); // [R02]
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic long_poly;
      logic [15:0] m;
      logic [15:0] taps;
      logic [3:0] pmask;
      logic [4:0] depth;
      logic [4:0] width;
      logic run;
      logic wen;
      logic pop;
      logic push;
      logic full;
      logic [15:0] word;
      logic [15:0] c;
      logic [15:0] rd_word;
      logic rd_hit;
      logic wr_hit;
      long_poly = s.poly_length_field > POLY_LENGTH_FIELD_SHORT_MAX;
      m = 16'hFFFF >> (4'hF - s.poly_length_field);
      // x^0 always present, x^1..x^15 from the term enables
      taps = {s.poly_terms, 1'b1}; // [R01] [R02]
      pmask = long_poly ? PTR_MASK_LONG : PTR_MASK_SHORT; // [R04]
      depth = long_poly ? DEPTH_LONG : DEPTH_SHORT; // [R04]
      width = {1'b0, s.poly_length_field} + 5'h01; // [R05]
      full = s.valid_word_count == depth; // [R09]
      // sleep, or idle with stop set, holds every engine flop as is
      run = s.shifter_go && !(sleep_mode || (idle_mode && s.idle_stop));
      wen = s.aw_got && s.w_got && !s.bvalid;
      pop = 1'b0;
      push = 1'b0;
      word = 16'h0000;
      c = s.crc;
      rd_word = 16'h0000;
      rd_hit = 1'b1;
      wr_hit = 1'b1;
      next_s = s;
      next_s.event_q = 1'b0;
      fifo_we = 1'b0;
      fifo_waddr = s.wr_ptr;
      fifo_wdata = 16'h0000;

      // write address and data channels, taken in either order
      if (s_axi_awvalid && !s.aw_got && !s.bvalid) begin
         next_s.aw_got = 1'b1;
         next_s.aw_idx = s_axi_awaddr[4:2];
      end
      if (s_axi_wvalid && !s.w_got && !s.bvalid) begin
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata[15:0];
         next_s.wstrb = s_axi_wstrb[1:0];
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end

      ///////////////////////////////////////////////////////////////////
      // shift engine
      if (run) begin // [R16] [R17] [R19]
         if (s.load_pend) begin
            next_s.shreg = fifo_rdata & m; // [R05]
            next_s.bits_left = width;
            next_s.load_pend = 1'b0;
         end else if (s.bits_left != 5'h00) begin
            // msb first, up to two bits this clock
            c = crcg_step(c, s.shreg[s.poly_length_field],
               s.poly_length_field, taps, m); // [R20]
            if (s.bits_left >= BITS_PER_CLK) begin
               c = crcg_step(c, s.shreg[s.poly_length_field - 4'h1],
                  s.poly_length_field, taps, m); // [R20]
               next_s.bits_left = s.bits_left - BITS_PER_CLK; // [R08]
            end else begin
               next_s.bits_left = 5'h00;
            end
            next_s.crc = c;
            next_s.shreg = (s.shreg << 2) & m;
         end
         // fetch next word as the current one finishes
         if (s.valid_word_count != 5'h00 && !s.load_pend &&
             s.bits_left <= BITS_PER_CLK) begin
            pop = 1'b1; // [R07]
         end
      end

      ///////////////////////////////////////////////////////////////////
      // register writes
      if (wen) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         unique case (s.aw_idx)
            OFS_CTRL[4:2]: begin
               if (s.wstrb[0]) begin
                  next_s.shifter_go = s.wdata[CTRL_GO_BIT]; // [R03] [R19]
                  next_s.poly_length_field =
                     s.wdata[CTRL_POLY_LENGTH_FIELD_LSB +: 4]; // [R01]
               end
               if (s.wstrb[1]) begin
                  next_s.idle_stop = s.wdata[CTRL_IDLE_BIT]; // [R17]
               end
            end
            OFS_POLY[4:2]: begin
               if (s.wstrb[0]) begin
                  next_s.poly_terms[7:1] = s.wdata[7:POLY_LSB]; // [R01]
               end
               if (s.wstrb[1]) begin
                  next_s.poly_terms[15:8] = s.wdata[15:8]; // [R01]
               end
            end
            OFS_WDAT[4:2]: begin
               // word completes on the byte that holds its msb
               if (long_poly) begin
                  if (s.wstrb[1]) begin
                     word = {s.wdata[15:8],
                        s.wstrb[0] ? s.wdata[7:0] : s.stage_lo}; // [R06]
                     push = 1'b1;
                  end else if (s.wstrb[0]) begin
                     next_s.stage_lo = s.wdata[7:0];
                  end
               end else if (s.wstrb[0]) begin
                  word = {8'h00, s.wdata[7:0]}; // [R06]
                  push = 1'b1;
               end
            end
            OFS_RESULT[4:2]: begin
               // software seed of the remainder
               if (s.wstrb[0]) begin
                  next_s.crc[7:0] = s.wdata[7:0] & m[7:0];
               end
               if (s.wstrb[1]) begin
                  next_s.crc[15:8] = s.wdata[15:8] & m[15:8];
               end
            end
            default: begin
               wr_hit = 1'b0;
            end
         endcase
         next_s.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end

      ///////////////////////////////////////////////////////////////////
      // fifo pointers and valid-word count
      if (pop) begin
         next_s.rd_ptr = (s.rd_ptr + 4'h1) & pmask;
         next_s.load_pend = 1'b1;
         next_s.valid_word_count = s.valid_word_count - 5'h01; // [R07]
         // pending event is raised even when frozen right after
         next_s.event_q = (s.valid_word_count == 5'h01) && !push; // [R11]
      end
      if (push) begin
         if (full) begin
            // overrun: drop the word and look empty, no event
            next_s.valid_word_count = 5'h00; // [R10]
            next_s.rd_ptr = s.wr_ptr; // [R10]
            next_s.event_q = 1'b0; // [R10]
         end else begin
            fifo_we = 1'b1;
            fifo_wdata = word & m; // [R05]
            next_s.wr_ptr = (s.wr_ptr + 4'h1) & pmask;
            next_s.valid_word_count = pop ? s.valid_word_count :
               s.valid_word_count + 5'h01; // [R06]
         end
      end

      ///////////////////////////////////////////////////////////////////
      // register reads, answered one cycle after the address
      if (s_axi_arvalid && !s.rvalid) begin
         unique case (s_axi_araddr[4:2])
            OFS_CTRL[4:2]: begin
               rd_word = {2'b00, s.idle_stop, s.valid_word_count,
                  full, s.valid_word_count == 5'h00, 1'b0,
                  s.shifter_go, s.poly_length_field}; // [R09] [R18]
            end
            OFS_POLY[4:2]: begin
               rd_word = {s.poly_terms, 1'b0};
            end
            // result is visible through the data register as well
            OFS_WDAT[4:2], OFS_RESULT[4:2]: begin
               rd_word = s.crc & m;
            end
            default: begin
               rd_hit = 1'b0;
            end
         endcase
         next_s.rvalid = 1'b1;
         next_s.rdata = rd_word;
         next_s.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.poly_terms <= RST_POLY[15:1];
         s.poly_length_field <= RST_POLY_LENGTH_FIELD;
         s.crc <= RST_CRC;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   crcg_fifo_mem u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(fifo_we),
      .wr_addr(fifo_waddr),
      .wr_data(fifo_wdata),
      .rd_addr(s.rd_ptr),
      .rd_data(fifo_rdata)
   );

   assign s_axi_awready = !s.aw_got && !s.bvalid;
   assign s_axi_wready = !s.w_got && !s.bvalid;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = !s.rvalid;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rdata = {16'h0000, s.rdata};
   assign crc_event = s.event_q;

endmodule

//--- verif/crcg_monitor.sv
// concurrent checks on the crc generator bus and event ports
`timescale 1ns/100ps
module crcg_monitor
   import crcg_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic crc_event
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wtake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write answer dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read answer dropped");
   property p_w_refuse;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_w_refuse: assert property (p_w_refuse)
      else $error("write taken while answer pending");
   property p_r_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_r_refuse: assert property (p_r_refuse)
      else $error("read taken while answer pending");
   property p_w_lat; s_wtake |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
   a_w_lat: assert property (p_w_lat)
      else $error("write answer late");
   property p_w_err;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
         s_axi_awaddr[4] |-> ##2 s_axi_bresp == RESP_SLVERR;
   endproperty
   a_w_err: assert property (p_w_err)
      else $error("unmapped write not refused");
   property p_r_err;
      s_axi_arvalid && s_axi_arready && s_axi_araddr[4] |=>
         s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_r_err: assert property (p_r_err)
      else $error("unmapped read not refused");
   property p_r_upper;
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
   endproperty
   a_r_upper: assert property (p_r_upper)
      else $error("read upper half not zero");
   property p_ev_pulse; crc_event |=> !crc_event; endproperty
   a_ev_pulse: assert property (p_ev_pulse)
      else $error("event longer than one cycle");
   c_event: cover property (crc_event);
   c_werr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
////////////////////////////////////////////////////////////////////////////
bind crcg_top crcg_monitor crcg_monitor_i (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .crc_event(crc_event));

//--- verif/tb_top.sv
// self-checking bench for the crc generator
`timescale 1ns/100ps
module tb_top
   import crcg_pkg::*;
;
   typedef struct {
      logic [4:0] a;
      logic [15:0] d;
      logic [15:0] e;
      logic [1:0] r;
   } crcg_row_t;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [4:0] awaddr = 5'h00;
   logic [4:0] araddr = 5'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic sleep_mode = 1'h0, idle_mode = 1'h0;
   wire logic awready, wready, bvalid, arready, rvalid, crc_event;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   int fail_count = 0, cmp_count = 0, ev_count = 0;
   logic [1:0] resp;
   logic [31:0] rv;
   crcg_row_t rows [6] = '{
      '{OFS_POLY, 16'hFFFF, 16'hFFFE, RESP_OKAY},
      '{OFS_POLY, 16'h1021, 16'h1020, RESP_OKAY},
      '{OFS_CTRL, 16'hFFFF, 16'h205F, RESP_OKAY},
      '{OFS_CTRL, 16'h0000, 16'h0040, RESP_OKAY},
      '{5'h10, 16'h1234, 16'h0000, RESP_SLVERR},
      '{5'h1C, 16'h5678, 16'h0000, RESP_SLVERR}};

   always #4 aclk = ~aclk;
   always @(posedge aclk) if (crc_event === 1'h1) ev_count <= ev_count + 1;

   crcg_top crcg_top_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sleep_mode(sleep_mode), .idle_mode(idle_mode), .crc_event(crc_event));

   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("counts: %0d compared, %0d mismatched", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic give_up;
      fail_count++;
      $display("MISMATCH wait expected done seen timeout");
      end_of_test();
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic rst;
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
   endtask
   // handshakes judged at the negedge before the taking edge
   task automatic wr(input logic [4:0] a, input logic [15:0] d,
         input logic [3:0] s);
      logic ta, tw, tbv;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      tbv = 1'h0;
      for (int n = 0; n < 50 && !tbv; n++) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tbv = bvalid;
         resp = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         if (tbv) bready <= 1'h0;
      end
      if (!tbv) give_up();
   endtask
   task automatic rd(input logic [4:0] a);
      logic ta, tr;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      tr = 1'h0;
      for (int n = 0; n < 50 && !tr; n++) begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid;
         rv = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'h0;
         if (tr) rready <= 1'h0;
      end
      if (!tr) give_up();
   endtask
   // bitwise msb-first reference, same result as two bits per clock
   function automatic logic [15:0] crc_ref(input logic [15:0] c,
         input logic [15:0] d, input logic [15:0] t);
      logic fb;
      for (int i = 15; i >= 0; i--) begin
         fb = c[15] ^ d[i];
         c = {c[14:0], 1'h0} ^ (fb ? {t[15:1], 1'h1} : 16'h0000);
      end
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial begin
      int e0;
      logic [15:0] exp_crc;
      rst();
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, 4'h3);
         chk("bresp", {30'h0, rows[i].r}, {30'h0, resp});
         rd(rows[i].a);
         chk("rresp", {30'h0, rows[i].r}, {30'h0, resp});
         chk("rdata", {16'h0000, rows[i].e}, rv);
      end
      $display("test table done");
      rst();
      rd(OFS_CTRL);
      chk("reset ctrl", 32'h0040, rv);
      rd(OFS_POLY);
      chk("reset poly", 32'h0000, rv);
      $display("test reset done");
      wr(OFS_POLY, 16'h1020, 4'h3);
      exp_crc = crc_ref(16'h0000, 16'h1234, 16'h1020);
      for (int k = 0; k < 2; k++) begin
         wr(OFS_RESULT, 16'h0000, 4'h3);
         idle_mode <= (k == 0);
         sleep_mode <= (k == 1);
         wr(OFS_CTRL, k == 0 ? 16'h201F : 16'h001F, 4'h3);
         e0 = ev_count;
         wr(OFS_WDAT, 16'h1234, 4'h3);
         repeat (20) @(posedge aclk);
         rd(OFS_CTRL);
         chk("frozen ctrl", k == 0 ? 32'h211F : 32'h011F, rv);
         if (k == 0) wr(OFS_CTRL, 16'h001F, 4'h3);
         else sleep_mode <= 1'h0;
         for (int n = 0; n < 40 && ev_count == e0; n++) @(posedge aclk);
         if (ev_count == e0) give_up();
         chk("events", e0 + 1, ev_count);
         repeat (9) @(posedge aclk);
         rd(OFS_WDAT);
         chk("crc", {16'h0000, exp_crc}, rv);
         rd(OFS_RESULT);
         chk("result", {16'h0000, exp_crc}, rv);
      end
      $display("test engine done");
      wr(OFS_CTRL, 16'h0007, 4'h3);
      for (int n = 0; n < 16; n++) wr(OFS_WDAT, 16'hFFA5, 4'h1);
      rd(OFS_CTRL);
      chk("full ctrl", 32'h1087, rv);
      e0 = ev_count;
      wr(OFS_WDAT, 16'h00A5, 4'h1);
      rd(OFS_CTRL);
      chk("wrap ctrl", 32'h0047, rv);
      chk("wrap events", e0, ev_count);
      wr(OFS_CTRL, 16'h000F, 4'h3);
      wr(OFS_WDAT, 16'h00FF, 4'h1);
      rd(OFS_CTRL);
      chk("low lane ctrl", 32'h004F, rv);
      for (int n = 0; n < 8; n++) wr(OFS_WDAT, 16'hBEEF, 4'h3);
      rd(OFS_CTRL);
      chk("full long", 32'h088F, rv);
      wr(OFS_CTRL, 16'h001F, 4'h3);
      for (int n = 0; n < 60; n++) begin
         rd(OFS_CTRL);
         if (rv[6] === 1'h1) break;
      end
      if (rv[6] !== 1'h1) give_up();
      chk("drained ctrl", 32'h005F, rv);
      $display("test fifo done");
      end_of_test();
   end
endmodule
